// File: rtl/lcm_pkg.sv
// Shared constants and types of the loss concealment mode selector
package lcm_pkg;

  // Concealment mode chosen for each frame
  typedef enum logic [2:0] {
    LCM_NORMAL,
    LCM_PM_ERASED,
    LCM_PM_NEXT_GOOD,
    LCM_PM_BURST,
    LCM_RS_ERASED,
    LCM_RS_NEXT_GOOD,
    LCM_AFTER_BURST,
    LCM_CONV_OLA
  } lcm_mode_t;

  // Thresholds on the energy difference, unsigned Q16 (value * 65536)
  localparam logic [15:0] STAT_THRES = 16'h083F;  // Below 0.032209
  localparam logic [15:0] MODE_THRES = 16'h28B9;  // Below 0.159063

  // Frequency window for the phase matching allow flag, in Hz
  localparam int PM_LOW_HZ = 75;
  localparam int PM_HIGH_HZ = 1000;

  // Number of buffered past frames checked for transients
  localparam int TRANS_DEPTH = 3;

  // Voiced noise attenuation as a right shift (factor 0.25)
  localparam int VOICED_SHIFT = 2;

  // Reset values
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_READY = 1'b1;

endpackage

// File: rtl/lcm_select.sv
// Concealment mode selection, sample synthesis and output buffer
//
// Contract
// - Output sample is sinusoid plus noise over whole extended segment.
// - Voiced frames: noise attenuated to one quarter before adding.
// - Summed signal overlap-added with previously decoded output.
// - Spectral repetition only on bad frame after frequency-domain frame.
// - Plain overlap-add: transform output plus stored previous signal.
// - Phase matching erased: count one, allow set, no continue; first.
// - Else next-good phase matching: previous bad, current good, continue.
// - Else phase matching burst: previous and current bad, continue set.
// - Allow flag needs maximum-energy band within 75 to 1000 Hz.
// - Allow flag needs band index change of at most one.
// - Allow flag needs small energy change, no transient in three frames.
// - Current stationarity set when energy difference below 0.032209.
// - Output stationarity copied only if equal to old; old always updated.
// - Erased frame: repetition if stationary or difference below 0.159063.
// - Erased non-stationary frame falls back to conventional overlap-add.
// - Stationary good frame after erasure: repetition for next good frame.
// - Non-stationary good frame after burst over one: after-burst mode.
// - Non-stationary good frame after single erasure: plain overlap-add.
`timescale 1ns/1ps

// Sample buffer with registered output stage
module lcm_fifo import lcm_pkg::*; #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = (count != '0) && (!out_valid_o || out_ready_i);

  // Occupancy of the memory
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  // Count and registered ready
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      count <= '0;
      in_ready_o <= RST_READY;
    end else begin
      count <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
    end
  end

  // Pointers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  // Storage
  always_ff @(posedge CLK_I) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Output stage
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      out_valid_o <= RST_FLAG;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rd_ptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule

// Frame-rate mode decision and sample-rate synthesis
module lcm_select import lcm_pkg::*; #(
  parameter int SW = 16,
  parameter int BW = 6,
  parameter int CW = 8,
  parameter int BAND_HZ = 25,
  parameter int FIFO_DEPTH = 16,
  parameter logic [15:0] ENERGY_CHANGE_LIMIT = 16'h1000
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic FRAME_VALID_I,
  input wire logic BFI_I,
  input wire logic FD_MODE_I,
  input wire logic [BW-1:0] MAX_BAND_I,
  input wire logic [15:0] ENERGY_CHANGE_I,
  input wire logic TRANSIENT_I,
  input wire logic [15:0] DIFF_ENERGY_I,
  output logic MODE_VALID_O,
  output lcm_mode_t MODE_O,
  output logic FD_CONCEAL_O,
  output logic PM_ALLOW_O,
  output logic STAT_OUT_O,
  output logic [CW-1:0] LOST_COUNT_O,
  input wire logic SAMPLE_VALID_I,
  output logic SAMPLE_READY_O,
  input wire logic SYNTH_SEL_I,
  input wire logic VOICED_I,
  input wire logic signed [SW-1:0] SIN_I,
  input wire logic signed [SW-1:0] NOISE_I,
  input wire logic signed [SW-1:0] IMDCT_I,
  input wire logic signed [SW-1:0] HIST_I,
  output logic SAMPLE_VALID_O,
  input wire logic SAMPLE_READY_I,
  output logic signed [SW+1:0] SAMPLE_O
);
  localparam int OW = SW + 2;
  localparam logic [BW-1:0] BAND_LO =
    BW'((PM_LOW_HZ + BAND_HZ - 1) / BAND_HZ);
  localparam logic [BW-1:0] BAND_HI = BW'(PM_HIGH_HZ / BAND_HZ);

  logic prev_bfi;
  logic prev_fd;
  logic pm_next;
  logic stat_old;
  logic [BW-1:0] prev_band;
  logic [TRANS_DEPTH-1:0] trans_hist;
  logic [CW-1:0] next_lost;
  logic stat_curr;
  logic next_stat_out;
  logic diff_low;
  logic stationary;
  logic band_ok;
  logic delta_ok;
  logic energy_ok;
  logic next_allow;
  logic fd_cond;
  lcm_mode_t next_mode;

  // Lost-frame count including the current frame when it is bad
  assign next_lost = (BFI_I && LOST_COUNT_O != '1) ?
                     LOST_COUNT_O + CW'(1) : LOST_COUNT_O;

  assign stat_curr = DIFF_ENERGY_I < STAT_THRES;
  assign next_stat_out = (stat_old == stat_curr) ? stat_curr : STAT_OUT_O;
  assign diff_low = DIFF_ENERGY_I < MODE_THRES;
  assign stationary = next_stat_out || diff_low;

  assign band_ok = (MAX_BAND_I >= BAND_LO) && (MAX_BAND_I <= BAND_HI);
  // band index moved by at most one
  assign delta_ok = ({1'b0, MAX_BAND_I} == {1'b0, prev_band}) ||
    ({1'b0, MAX_BAND_I} == {1'b0, prev_band} + (BW+1)'(1)) ||
    ({1'b0, prev_band} == {1'b0, MAX_BAND_I} + (BW+1)'(1));
  assign energy_ok = (ENERGY_CHANGE_I < ENERGY_CHANGE_LIMIT) &&
                     (trans_hist == '0);
  assign next_allow = band_ok && delta_ok && energy_ok;
  assign fd_cond = BFI_I && prev_fd;

  // Mode priority chain
  always_comb begin
    next_mode = LCM_NORMAL;
    if (BFI_I && next_lost == CW'(1) && PM_ALLOW_O && !pm_next) begin
      next_mode = LCM_PM_ERASED;
    end else if (prev_bfi && !BFI_I && pm_next) begin
      next_mode = LCM_PM_NEXT_GOOD;
    end else if (prev_bfi && BFI_I && pm_next) begin
      next_mode = LCM_PM_BURST;
    end else if (BFI_I) begin
      next_mode = stationary ? LCM_RS_ERASED : LCM_CONV_OLA;
    end else if (prev_bfi && stationary) begin
      next_mode = LCM_RS_NEXT_GOOD;
    end else if (prev_bfi) begin
      next_mode = (LOST_COUNT_O > CW'(1)) ? LCM_AFTER_BURST : LCM_CONV_OLA;
    end
  end

  // Mode output and strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      MODE_VALID_O <= RST_FLAG;
      MODE_O <= LCM_NORMAL;
      pm_next <= RST_FLAG;
    end else begin
      MODE_VALID_O <= FRAME_VALID_I;
      if (FRAME_VALID_I) begin
        MODE_O <= next_mode;
        pm_next <= (next_mode == LCM_PM_ERASED) ||
                   (next_mode == LCM_PM_BURST);
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      FD_CONCEAL_O <= RST_FLAG;
      prev_fd <= RST_FLAG;
    end else if (FRAME_VALID_I) begin
      FD_CONCEAL_O <= fd_cond;
      prev_fd <= FD_MODE_I;
    end
  end

  // lost count and previous bad-frame flag
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      LOST_COUNT_O <= '0;
      prev_bfi <= RST_FLAG;
    end else if (FRAME_VALID_I) begin
      LOST_COUNT_O <= BFI_I ? next_lost : '0;
      prev_bfi <= BFI_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      stat_old <= RST_FLAG;
      STAT_OUT_O <= RST_FLAG;
    end else if (FRAME_VALID_I) begin
      stat_old <= stat_curr;
      STAT_OUT_O <= next_stat_out;
    end
  end

  // Good-frame memory update of the allow flag
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PM_ALLOW_O <= RST_FLAG;
      prev_band <= '0;
      trans_hist <= '0;
    end else if (FRAME_VALID_I && !BFI_I) begin
      PM_ALLOW_O <= next_allow;
      prev_band <= MAX_BAND_I;
      trans_hist <= {trans_hist[TRANS_DEPTH-2:0], TRANSIENT_I};
    end
  end

  // Sample synthesis
  logic signed [OW-1:0] sin_x;
  logic signed [OW-1:0] noise_x;
  logic signed [OW-1:0] noise_q;
  logic signed [OW-1:0] synth;
  logic signed [OW-1:0] push_data;
  logic push;

  assign sin_x = OW'(SIN_I);
  assign noise_x = OW'(NOISE_I);
  // voiced noise scaled by one quarter
  assign noise_q = VOICED_I ? (noise_x >>> VOICED_SHIFT) : noise_x;
  assign synth = sin_x + noise_q;
  assign push_data = (SYNTH_SEL_I ? synth : OW'(IMDCT_I)) + OW'(HIST_I);
  assign push = SAMPLE_VALID_I && SAMPLE_READY_O;

  lcm_fifo #(
    .WIDTH(OW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .in_valid_i(SAMPLE_VALID_I),
    .in_ready_o(SAMPLE_READY_O),
    .in_data_i(push_data),
    .out_valid_o(SAMPLE_VALID_O),
    .out_ready_i(SAMPLE_READY_I),
    .out_data_o(SAMPLE_O)
  );

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_synth_sum: assert property (
    push && SYNTH_SEL_I && !VOICED_I |->
      push_data == OW'(SIN_I) + OW'(NOISE_I) + OW'(HIST_I))
    else $error("Unvoiced synthesis sum wrong");
  a_voiced_quarter: assert property (
    push && SYNTH_SEL_I && VOICED_I |->
      push_data == OW'(SIN_I) + (OW'(NOISE_I) >>> 2) + OW'(HIST_I))
    else $error("Voiced noise not quartered");
  a_hist_overlap: assert property (
    push && SYNTH_SEL_I |-> push_data == OW'(SIN_I) + OW'(HIST_I) +
      (VOICED_I ? (OW'(NOISE_I) >>> 2) : OW'(NOISE_I)))
    else $error("Previous output not overlap-added");
  a_fd_repeat: assert property (
    FRAME_VALID_I |=> FD_CONCEAL_O == ($past(BFI_I) && $past(prev_fd)))
    else $error("Spectral repetition flag wrong");
  a_conv_ola: assert property (
    push && !SYNTH_SEL_I |-> push_data == OW'(IMDCT_I) + OW'(HIST_I))
    else $error("Conventional overlap-add sum wrong");
  a_pm_erased: assert property (
    FRAME_VALID_I && BFI_I && LOST_COUNT_O == '0 && PM_ALLOW_O && !pm_next
      |=> MODE_O == LCM_PM_ERASED)
    else $error("Erased-frame phase matching missed");
  a_pm_next: assert property (
    FRAME_VALID_I && prev_bfi && !BFI_I && pm_next
      |=> MODE_O == LCM_PM_NEXT_GOOD)
    else $error("Next-good phase matching missed");
  a_pm_burst: assert property (
    FRAME_VALID_I && prev_bfi && BFI_I && pm_next
      |=> MODE_O == LCM_PM_BURST ##1 MODE_VALID_O == 1'b0 || MODE_O != 0)
    else $error("Burst phase matching missed");
  a_allow_band: assert property (
    FRAME_VALID_I && !BFI_I &&
      (int'(MAX_BAND_I) * BAND_HZ < PM_LOW_HZ ||
       int'(MAX_BAND_I) * BAND_HZ > PM_HIGH_HZ) |=> !PM_ALLOW_O)
    else $error("Allow set outside frequency window");
  a_allow_delta: assert property (
    FRAME_VALID_I && !BFI_I &&
      (int'(MAX_BAND_I) > int'(prev_band) + 1 ||
       int'(prev_band) > int'(MAX_BAND_I) + 1) |=> !PM_ALLOW_O)
    else $error("Allow set despite band jump");
  a_allow_energy: assert property (
    FRAME_VALID_I && !BFI_I &&
      (ENERGY_CHANGE_I >= ENERGY_CHANGE_LIMIT || trans_hist != '0)
      |=> !PM_ALLOW_O)
    else $error("Allow set despite energy or transient");
  a_trans_hist: assert property (
    FRAME_VALID_I && !BFI_I |=> trans_hist[0] == $past(TRANSIENT_I))
    else $error("Transient history not updated");
  a_stat_set: assert property (
    FRAME_VALID_I && DIFF_ENERGY_I < STAT_THRES |=> stat_old)
    else $error("Stationarity not set");
  a_stat_hold: assert property (
    FRAME_VALID_I && stat_old != stat_curr |=> $stable(STAT_OUT_O))
    else $error("Output stationarity changed without agreement");
  a_rs_erased: assert property (
    FRAME_VALID_I && BFI_I && !pm_next && !PM_ALLOW_O &&
      DIFF_ENERGY_I < MODE_THRES
      |=> MODE_O == LCM_RS_ERASED)
    else $error("Erased repetition missed");
  a_erased_ola: assert property (
    FRAME_VALID_I && BFI_I && !pm_next && !PM_ALLOW_O && !stationary
      |=> MODE_O == LCM_CONV_OLA)
    else $error("Erased fallback missed");
  a_rs_next: assert property (
    FRAME_VALID_I && prev_bfi && !BFI_I && !pm_next && stationary
      |=> MODE_O == LCM_RS_NEXT_GOOD)
    else $error("Next-good repetition missed");
  a_after_burst: assert property (
    FRAME_VALID_I && prev_bfi && !BFI_I && !pm_next && !stationary &&
      LOST_COUNT_O > CW'(1) |=> MODE_O == LCM_AFTER_BURST)
    else $error("After-burst mode missed");
  a_single_ola: assert property (
    FRAME_VALID_I && prev_bfi && !BFI_I && !pm_next && !stationary &&
      LOST_COUNT_O == CW'(1) |=> MODE_O == LCM_CONV_OLA)
    else $error("Single-erasure fallback missed");
  a_stat_clear: assert property (
    FRAME_VALID_I && DIFF_ENERGY_I >= STAT_THRES |=> !stat_old)
    else $error("Stationarity not cleared");
  a_lost_count: assert property (
    FRAME_VALID_I && !BFI_I |=> LOST_COUNT_O == '0 && !prev_bfi)
    else $error("Lost count not cleared on good frame");

  c_pm_burst: cover property (MODE_VALID_O && MODE_O == LCM_PM_BURST);
  c_after_burst: cover property (MODE_VALID_O && MODE_O == LCM_AFTER_BURST);
  c_fifo_full: cover property (!SAMPLE_READY_O ##1 SAMPLE_READY_O);
endmodule

// File: tb/lcm_sink.sv
// Sample consumer model with random back-pressure
`timescale 1ns/1ps
module lcm_sink (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic hold_i,
  output logic ready_o
);
  initial ready_o = 1'b0;
  // Ready redrawn after each edge, forced low while held
  always @(posedge CLK_I) begin
    #1 ready_o <= !RST_I && !hold_i && ($urandom_range(3) != 0);
  end
endmodule

// File: tb/loss_concealment_mode_select_tb.sv
// Self-checking bench of the concealment mode selector
`timescale 1ns/1ps
module loss_concealment_mode_select_tb;
  import lcm_pkg::*;
  localparam logic [15:0] LIM = 16'h1000;
  localparam int BLO = (PM_LOW_HZ + 24) / 25;
  localparam int BHI = PM_HIGH_HZ / 25;
  localparam logic [5:0] PAT = 6'b010111;
  logic CLK_I = 0, RST_I = 1, FRAME_VALID_I = 0, BFI_I = 0, FD_MODE_I = 0;
  logic TRANSIENT_I = 0, SAMPLE_VALID_I = 0, SYNTH_SEL_I = 0, VOICED_I = 0;
  logic [5:0] MAX_BAND_I = 0;
  logic [15:0] ENERGY_CHANGE_I = 0, DIFF_ENERGY_I = 0;
  logic signed [15:0] SIN_I = 0, NOISE_I = 0, IMDCT_I = 0, HIST_I = 0;
  logic MODE_VALID_O, FD_CONCEAL_O, PM_ALLOW_O, STAT_OUT_O, SAMPLE_READY_O;
  logic SAMPLE_VALID_O, SAMPLE_READY_I, hold = 1;
  lcm_mode_t MODE_O;
  logic [7:0] LOST_COUNT_O, mc;
  logic signed [17:0] SAMPLE_O;
  logic signed [17:0] q[$];
  int num_errors = 0, n_compared = 0, a;
  logic pb, pf, al, so, ol, ct;
  logic [5:0] mb;
  logic [2:0] hs;

  lcm_select #(.ENERGY_CHANGE_LIMIT(LIM)) DUT (.CLK_I(CLK_I), .RST_I(RST_I),
    .FRAME_VALID_I(FRAME_VALID_I), .BFI_I(BFI_I), .FD_MODE_I(FD_MODE_I),
    .MAX_BAND_I(MAX_BAND_I), .ENERGY_CHANGE_I(ENERGY_CHANGE_I),
    .TRANSIENT_I(TRANSIENT_I), .DIFF_ENERGY_I(DIFF_ENERGY_I),
    .MODE_VALID_O(MODE_VALID_O), .MODE_O(MODE_O),
    .FD_CONCEAL_O(FD_CONCEAL_O), .PM_ALLOW_O(PM_ALLOW_O),
    .STAT_OUT_O(STAT_OUT_O), .LOST_COUNT_O(LOST_COUNT_O),
    .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_READY_O(SAMPLE_READY_O),
    .SYNTH_SEL_I(SYNTH_SEL_I), .VOICED_I(VOICED_I), .SIN_I(SIN_I),
    .NOISE_I(NOISE_I), .IMDCT_I(IMDCT_I), .HIST_I(HIST_I),
    .SAMPLE_VALID_O(SAMPLE_VALID_O), .SAMPLE_READY_I(SAMPLE_READY_I),
    .SAMPLE_O(SAMPLE_O));
  lcm_sink sink (.CLK_I(CLK_I), .RST_I(RST_I), .hold_i(hold),
    .ready_o(SAMPLE_READY_I));

  initial forever #4 CLK_I = ~CLK_I;

  task automatic chk(input logic [17:0] g, e);
    n_compared++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask

  task results;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Expected sample: sinusoid plus scaled noise, or transform, plus history
  function automatic logic signed [17:0] samp(logic s, v,
      logic signed [15:0] x, n, m, h);
    logic signed [17:0] z;
    z = n;
    if (v) z = z >>> VOICED_SHIFT;
    return (s ? x + z : m) + h;
  endfunction

  // Expected mode from the stored frame history
  function automatic lcm_mode_t decide(logic b, st, logic [7:0] cn);
    if (b && cn == 8'h01 && al && !ct) return LCM_PM_ERASED;
    if (pb && !b && ct) return LCM_PM_NEXT_GOOD;
    if (pb && b && ct) return LCM_PM_BURST;
    if (b) return st ? LCM_RS_ERASED : LCM_CONV_OLA;
    if (!pb) return LCM_NORMAL;
    if (st) return LCM_RS_NEXT_GOOD;
    return (mc > 8'h01) ? LCM_AFTER_BURST : LCM_CONV_OLA;
  endfunction

  // One frame strobe, model update and check of the answer
  task automatic fr(input logic b, f, input logic [5:0] bd,
      input logic [15:0] ec, df, input logic tr);
    logic st, fc, cur;
    logic [7:0] cn;
    lcm_mode_t em;
    FRAME_VALID_I = 1;
    BFI_I = b;
    FD_MODE_I = f;
    MAX_BAND_I = bd;
    ENERGY_CHANGE_I = ec;
    DIFF_ENERGY_I = df;
    TRANSIENT_I = tr;
    cn = !b ? 8'h00 : (mc == 8'hFF) ? mc : mc + 8'h01;
    cur = df < STAT_THRES;
    if (cur == ol) so = cur;
    ol = cur;
    st = so || df < MODE_THRES;
    em = decide(b, st, cn);
    fc = b && pf;
    if (!b) begin
      al = bd >= BLO && bd <= BHI && ec < LIM && hs == 3'b000 &&
        ((bd > mb) ? bd - mb : mb - bd) <= 1;
      hs = {hs[1:0], tr};
      mb = bd;
    end
    @(posedge CLK_I);
    #1;
    chk(MODE_VALID_O, 1);
    chk(MODE_O, em);
    chk(FD_CONCEAL_O, fc);
    chk(PM_ALLOW_O, al);
    chk(STAT_OUT_O, so);
    chk(LOST_COUNT_O, cn);
    pf = f;
    pb = b;
    mc = cn;
    ct = em == LCM_PM_ERASED || em == LCM_PM_BURST;
  endtask

  task automatic gap;
    FRAME_VALID_I = 0;
    @(posedge CLK_I);
    #1;
    chk(MODE_VALID_O, 0);
  endtask

  // Random frame with boundary thresholds, sometimes back to back
  task automatic rfr;
    logic [15:0] d[5];
    d = '{STAT_THRES - 16'h0001, STAT_THRES, MODE_THRES - 16'h0001,
      MODE_THRES, 16'($urandom)};
    fr($urandom_range(9) < 4, $urandom_range(1),
      ($urandom_range(3) == 0) ?
        6'($urandom) : mb + 6'($urandom_range(2)) - 6'h01,
      $urandom_range(1) ? LIM - 16'h0001 : LIM, d[$urandom_range(4)],
      $urandom_range(15) == 0);
    if ($urandom_range(2) == 0) gap;
  endtask

  task automatic rst;
    RST_I = 1;
    FRAME_VALID_I = 0;
    repeat (8) @(posedge CLK_I);
    #1;
    chk(MODE_O, LCM_NORMAL);
    chk(LOST_COUNT_O, 0);
    chk(SAMPLE_VALID_O, 0);
    RST_I = 0;
    {pb, pf, al, so, ol, ct, mb, hs, mc} = '0;
    q.delete();
    repeat (3) fr(0, 0, 6'h00, 0, 0, 0);
  endtask

  // Offer up to n samples, stop at the first one refused for w edges
  task automatic put(input int n, w, output int na);
    int k;
    logic ok;
    na = 0;
    repeat (n) begin
      SYNTH_SEL_I = $urandom_range(1);
      VOICED_I = $urandom_range(1);
      SIN_I = 16'($urandom);
      NOISE_I = 16'($urandom);
      IMDCT_I = 16'($urandom);
      HIST_I = 16'($urandom);
      SAMPLE_VALID_I = 1;
      k = 0;
      do begin
        @(posedge CLK_I);
        ok = SAMPLE_READY_O;
        k++;
      end while (ok !== 1'b1 && k < w);
      #1;
      if (ok !== 1'b1) break;
      q.push_back(samp(SYNTH_SEL_I, VOICED_I, SIN_I, NOISE_I, IMDCT_I,
        HIST_I));
      na++;
    end
    SAMPLE_VALID_I = 0;
  endtask

  task automatic drain;
    int k;
    k = 0;
    while (q.size() != 0 && k < 600) begin
      @(posedge CLK_I);
      k++;
    end
    #9;
    chk(q.size(), 0);
    chk(SAMPLE_VALID_O, 0);
  endtask

  // Compare each sample taken by the consumer in order
  always @(posedge CLK_I) begin
    if (!RST_I && SAMPLE_VALID_O === 1'b1 && SAMPLE_READY_I === 1'b1) begin
      if (q.size() != 0) chk(SAMPLE_O, q.pop_front());
      else chk(SAMPLE_VALID_O, 0);
    end
  end

  initial begin
    void'($urandom(6));
    rst;
    // phase matching chain on a settled band
    repeat (4) fr(0, 0, 6'h05, 0, 0, 0);
    for (int i = 0; i < 6; i++) fr(PAT[i], 1, 6'h05, 0, 0, 0);
    fr(0, 0, 6'h00, 0, MODE_THRES, 0);
    repeat (2) fr(1, 0, 6'h00, 0, MODE_THRES, 0);
    fr(0, 0, 6'h00, 0, MODE_THRES, 0);
    repeat (400) rfr;
    gap;
    rst;
    repeat (100) rfr;
    gap;
    // Fill the buffer with the consumer stalled, then drain
    put(20, 4, a);
    chk(a, 17);
    hold = 0;
    drain;
    put(200, 60, a);
    chk(a, 200);
    drain;
    results;
  end

  initial begin
    #400_000;
    num_errors++;
    results;
  end
endmodule
